//--- rtl/csw_pkg.sv
// constants shared by the bus switch control logic
// assumes a single 10 MHz system clock and an upstream serial bus up to 400 kHz
package csw_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    // fixed upper four bits of the target address (arbitrary value)
    localparam logic [3:0] ADDR_FIXED_HI = 4'he;
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned BYTE_BITS = 8;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam int unsigned RW_BIT = 0;
    // least reset low pulse, in ns
    localparam int unsigned MIN_RESET_LOW_PULSE_NS = 500;
    localparam int unsigned RST_CYCLES =
        (MIN_RESET_LOW_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [3:0] RST_CNT_MAX = 4'(RST_CYCLES);
    typedef enum logic [2:0] {
        CSW_IDLE = 3'b000,
        CSW_ADDR = 3'b001,
        CSW_AACK = 3'b010,
        CSW_WDAT = 3'b011,
        CSW_WACK = 3'b100,
        CSW_RDAT = 3'b101,
        CSW_RACK = 3'b110
    } csw_state_t;
endpackage : csw_pkg

//--- rtl/csw_sync.sv
// two flip-flop synchroniser for one input from outside the clock domain
// assumes i_clk_sys and an asynchronous active-low reset
module csw_sync (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // data
    input wire logic i_async,
    output logic o_sync
);
    logic meta_reg;
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            meta_reg <= 1'b1;
            o_sync <= 1'b1;
        end
        else
        begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule : csw_sync

//--- rtl/csw_rst_filter.sv
// qualifies the external reset pin: accepted only after a minimum low time
// assumes the pin arrives already synchronised
module csw_rst_filter (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // pin level
    input wire logic i_pin_sync,
    output logic o_soft_rst
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic hit_reg;
    logic hit_next;
    always_comb
    begin
        cnt_next = 4'h0;
        hit_next = 1'b0;
        if (!i_pin_sync)
        begin
            cnt_next = (cnt_reg == csw_pkg::RST_CNT_MAX) ? cnt_reg
                : cnt_reg + 4'h1;
            hit_next = (cnt_next == csw_pkg::RST_CNT_MAX); // R15
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            cnt_reg <= 4'h0;
            hit_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            hit_reg <= hit_next;
        end
    end
    assign o_soft_rst = hit_reg;
endmodule : csw_rst_filter

//--- rtl/csw_switch.sv
// Contract
// R1: master sends the seven bit target address right after start.
// R2: three strap inputs form part of the target address.
// R3: eighth bit after address: one reads, zero writes.
// R4: after address ack on write, next byte goes to control register.
// R5: with several data bytes only the last one is kept.
// R6: control register is writable and readable; read gives channel status.
// R7: only low four bits select channels, bit n enables channel n.
// R8: new selection takes effect only at the following stop condition.
// R9: master issues stop right after the control byte acknowledge.
// R10: power-up and reset clear the control register to zero.
// R11: any combination of channels may be connected together.
// R12: reset pin low returns bus logic to idle, deselects channels.
// R13: power-on reset has the same effect as the reset pin.
// R14: serial interface works at any clock from zero to 400 kHz.
// R15: reset pin counts only after a minimum low pulse width.
// R16: each received byte is acknowledged by holding data low.
// R17: after power-on release, register and bus logic start at zero.
// R18: address is fixed upper bits plus straps; mismatches ignored.
//
// control logic of a four channel upstream bus switch
// assumes i_rst_b is the internal power-on reset; all pins are asynchronous
module csw_switch (
    // clock and power-on reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // reset pin and address straps
    input wire logic i_reset_pin_b,
    input wire logic i_addr_strap_bit0,
    input wire logic i_addr_strap_bit1,
    input wire logic i_addr_strap_bit2,
    // upstream bus
    input wire logic i_up_clk,
    input wire logic i_up_data,
    output logic o_up_data_out,
    output logic o_up_data_oe,
    // downstream channel connections and register image
    output logic [3:0] o_ch_connect,
    output logic [7:0] o_channel_select
);
    logic scl_s;
    logic sda_s;
    logic rpin_s;
    logic [2:0] strap_s;
    logic soft_rst;

    // every pin passes two flip-flops before any logic reads it
    csw_sync u_sync_scl (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_async(i_up_clk),
        .o_sync(scl_s)
    );
    csw_sync u_sync_sda (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_async(i_up_data),
        .o_sync(sda_s)
    );
    csw_sync u_sync_rst (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_async(i_reset_pin_b),
        .o_sync(rpin_s)
    );
    csw_sync u_sync_a0 (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_async(i_addr_strap_bit0),
        .o_sync(strap_s[0])
    );
    csw_sync u_sync_a1 (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_async(i_addr_strap_bit1),
        .o_sync(strap_s[1])
    );
    csw_sync u_sync_a2 (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_async(i_addr_strap_bit2),
        .o_sync(strap_s[2])
    );
    csw_rst_filter u_rst_filter (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_pin_sync(rpin_s),
        .o_soft_rst(soft_rst)
    );

    // edge and condition detection on synchronised lines
    logic scl_d_reg;
    logic scl_d_next;
    logic sda_d_reg;
    logic sda_d_next;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    always_comb
    begin
        scl_d_next = scl_s;
        sda_d_next = sda_s;
        scl_rise = scl_s && !scl_d_reg;
        scl_fall = !scl_s && scl_d_reg;
        // data falls while clock stays high
        start_cond = scl_s && scl_d_reg && sda_d_reg && !sda_s;
        // data rises while clock stays high
        stop_cond = scl_s && scl_d_reg && !sda_d_reg && sda_s;
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else
        begin
            scl_d_reg <= scl_d_next;
            sda_d_reg <= sda_d_next;
        end
    end

    // bus state machine, register and outputs
    csw_pkg::csw_state_t state_reg;
    csw_pkg::csw_state_t state_next;
    logic [3:0] bit_reg;
    logic [3:0] bit_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [3:0] conn_reg;
    logic [3:0] conn_next;
    logic oe_reg;
    logic oe_next;
    logic dout_reg;
    logic dout_next;
    logic addr_match;
    logic rd_req;
    logic [6:0] my_addr;
    logic [csw_pkg::NUM_CH-1:0] ch_enable;
    assign my_addr = {csw_pkg::ADDR_FIXED_HI, strap_s}; // R2 R18
    assign addr_match = (shift_reg[7:1] == my_addr); // R18
    assign rd_req = shift_reg[csw_pkg::RW_BIT]; // R3

    // each channel follows its own enable bit
    genvar ch;
    generate
        for (ch = 0; ch < csw_pkg::NUM_CH; ch = ch + 1)
        begin : g_chan
            assign ch_enable[ch] = ctrl_reg[ch]; // R7 R11
        end
    endgenerate

    always_comb
    begin
        state_next = state_reg;
        bit_next = bit_reg;
        shift_next = shift_reg;
        ctrl_next = ctrl_reg;
        conn_next = conn_reg;
        oe_next = oe_reg;
        dout_next = 1'b0;
        if (soft_rst)
        begin
            state_next = csw_pkg::CSW_IDLE; // R12
            bit_next = 4'h0;
            shift_next = csw_pkg::CTRL_RESET;
            ctrl_next = csw_pkg::CTRL_RESET; // R12 R15
            conn_next = 4'h0;
            oe_next = 1'b0;
        end
        else if (start_cond)
        begin
            state_next = csw_pkg::CSW_ADDR; // R1
            bit_next = 4'h0;
            oe_next = 1'b0;
        end
        else if (stop_cond)
        begin
            state_next = csw_pkg::CSW_IDLE;
            bit_next = 4'h0;
            oe_next = 1'b0;
            // R8 R9 R7 R11
            conn_next = ch_enable;
        end
        else
        begin
            case (state_reg)
                csw_pkg::CSW_ADDR, csw_pkg::CSW_WDAT:
                begin
                    if (scl_rise)
                    begin
                        shift_next = {shift_reg[6:0], sda_s};
                        bit_next = bit_reg + 4'h1;
                    end
                    else if (scl_fall && bit_reg == csw_pkg::BIT_ACK)
                    begin
                        bit_next = 4'h0;
                        if (state_reg == csw_pkg::CSW_WDAT)
                        begin
                            ctrl_next = shift_reg; // R4 R5
                            oe_next = 1'b1; // R16
                            state_next = csw_pkg::CSW_WACK;
                        end
                        else if (addr_match)
                        begin
                            oe_next = 1'b1; // R16
                            state_next = csw_pkg::CSW_AACK;
                        end
                        else
                        begin
                            state_next = csw_pkg::CSW_IDLE; // R18
                        end
                    end
                end
                csw_pkg::CSW_AACK, csw_pkg::CSW_WACK:
                begin
                    if (scl_fall)
                    begin
                        bit_next = 4'h0;
                        if (state_reg == csw_pkg::CSW_AACK && rd_req)
                        begin
                            // R3 R6
                            shift_next = ctrl_reg;
                            oe_next = !ctrl_reg[7];
                            state_next = csw_pkg::CSW_RDAT;
                        end
                        else
                        begin
                            oe_next = 1'b0; // R3
                            state_next = csw_pkg::CSW_WDAT;
                        end
                    end
                end
                csw_pkg::CSW_RDAT:
                begin
                    if (scl_fall)
                    begin
                        if (bit_reg == csw_pkg::BIT_LAST)
                        begin
                            oe_next = 1'b0;
                            state_next = csw_pkg::CSW_RACK;
                        end
                        else
                        begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            oe_next = !shift_reg[6];
                            bit_next = bit_reg + 4'h1;
                        end
                    end
                end
                csw_pkg::CSW_RACK:
                begin
                    if (scl_rise)
                    begin
                        bit_next = 4'h0;
                        // master ack: send again; nack: release
                        shift_next[csw_pkg::RW_BIT] = 1'b1; // R6
                        state_next = sda_s ? csw_pkg::CSW_IDLE
                            : csw_pkg::CSW_AACK;
                    end
                end
                default:
                begin
                    state_next = csw_pkg::CSW_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_reg <= csw_pkg::CSW_IDLE; // R13 R17
            bit_reg <= 4'h0;
            shift_reg <= csw_pkg::CTRL_RESET;
            ctrl_reg <= csw_pkg::CTRL_RESET; // R10 R13 R17
            conn_reg <= 4'h0;
            oe_reg <= 1'b0;
            dout_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
            ctrl_reg <= ctrl_next;
            conn_reg <= conn_next;
            oe_reg <= oe_next;
            dout_reg <= dout_next;
        end
    end

    // 10 MHz oversampling covers upstream clocks from dc to 400 kHz  R14
    assign o_up_data_out = dout_reg;
    assign o_up_data_oe = oe_reg;
    assign o_ch_connect = conn_reg;
    assign o_channel_select = ctrl_reg;
endmodule : csw_switch

//--- sim/csw_switch_checker.sv
// port assertions for the bus switch control logic
// assumes the 10 MHz system clock and the raw bus levels at the ports
module csw_switch_checker (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_reset_pin_b,
    input wire logic i_up_clk,
    input wire logic i_up_data,
    input wire logic o_up_data_out,
    input wire logic o_up_data_oe,
    input wire logic [3:0] o_ch_connect,
    input wire logic [7:0] o_channel_select
);
    logic clk_reg, dat_reg;
    logic [3:0] stp_reg, stp_next, low_reg, low_next;
    always_comb
    begin
        stp_next = (stp_reg == 4'hf) ? stp_reg : stp_reg + 4'h1;
        if (i_up_clk && clk_reg && i_up_data && !dat_reg)
            stp_next = 4'h0;
        low_next = (low_reg == 4'hf) ? low_reg : low_reg + 4'h1;
        if (i_reset_pin_b)
            low_next = 4'h0;
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            clk_reg <= 1'b1;
            dat_reg <= 1'b1;
            stp_reg <= 4'hf;
            low_reg <= 4'h0;
        end
        else
        begin
            clk_reg <= i_up_clk;
            dat_reg <= i_up_data;
            stp_reg <= stp_next;
            low_reg <= low_next;
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    chk_out_low: assert property (o_up_data_out == 1'b0)
        else $error("data out not low");
    chk_conn_match: assert property ($changed(o_ch_connect)
        |-> o_ch_connect == o_channel_select[3:0])
        else $error("connections differ from register");
    chk_conn_stop: assert property ($changed(o_ch_connect)
        |-> stp_reg < 4'h8 || low_reg != 4'h0)
        else $error("connections changed without stop");
    chk_pin_clear: assert property (low_reg == 4'hc
        |-> o_ch_connect == 4'h0 && o_channel_select == 8'h00
        && !o_up_data_oe)
        else $error("reset pin did not clear");
    chk_short_pulse: assert property (i_reset_pin_b
        ##1 !i_reset_pin_b [*3] ##1 i_reset_pin_b
        |-> ##3 o_channel_select == $past(o_channel_select, 7))
        else $error("short reset pulse acted");
    chk_oe_edge: assert property ($changed(o_up_data_oe)
        |-> !i_up_clk)
        else $error("data drive changed while clock high");
    chk_reset_zero: assert property ($rose(i_rst_b)
        |-> o_channel_select == 8'h00 && o_ch_connect == 4'h0)
        else $error("register not zero after reset");
    chk_sel_change: assert property ($changed(o_channel_select)
        |-> !i_up_clk || low_reg != 4'h0)
        else $error("register changed while clock high");
    cover property ($changed(o_ch_connect));
    cover property ($rose(o_up_data_oe));
    cover property (low_reg == 4'hc);
endmodule : csw_switch_checker
bind csw_switch csw_switch_checker chk_u (.i_clk_sys, .i_rst_b,
    .i_reset_pin_b, .i_up_clk, .i_up_data, .o_up_data_out,
    .o_up_data_oe, .o_ch_connect, .o_channel_select);

//--- sim/csw_master_model.sv
// upstream bus master model, 800 ns bus clock period
// assumes a pulled-up data wire resolved by the bench
module csw_master_model (
    input wire logic i_clk_sys,
    input wire logic i_up_data,
    output logic o_up_clk,
    output logic o_data_low
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        o_up_clk = 1'b1;
        o_data_low = 1'b0;
    end
    task wait_cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask : wait_cyc
    // start, then the address byte follows
    task start_cond;
        o_data_low <= 1'b0;
        wait_cyc(2);
        o_up_clk <= 1'b1;
        wait_cyc(4);
        o_data_low <= 1'b1;
        wait_cyc(4);
        o_up_clk <= 1'b0;
        wait_cyc(2);
    endtask : start_cond
    // stop right after the acknowledge cycle
    task stop_cond;
        o_data_low <= 1'b1;
        wait_cyc(2);
        o_up_clk <= 1'b1;
        wait_cyc(4);
        o_data_low <= 1'b0;
        wait_cyc(4);
    endtask : stop_cond
    // four cycles per clock phase give an 800 ns, 1.25 MHz bus clock
    task bit_xfer(input logic b, output logic s);
        o_data_low <= ~b;
        wait_cyc(2);
        o_up_clk <= 1'b1;
        wait_cyc(2);
        s = i_up_data;
        wait_cyc(2);
        o_up_clk <= 1'b0;
        wait_cyc(2);
    endtask : bit_xfer
    // msb first, last bit of an address byte is the direction
    task byte_xfer(input logic [7:0] tx, input logic mack,
        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_xfer(tx[i], rx[i]);
        bit_xfer(mack, ack);
    endtask : byte_xfer
endmodule : csw_master_model

//--- sim/tb.sv
// self-checking bench for the bus switch control logic
// assumes the master model drives the bus and a pull-up on data
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk;
    logic rst_b;
    logic pin_b;
    logic oe;
    logic dout;
    logic ack;
    logic a0;
    logic a1;
    logic [2:0] strap;
    logic [3:0] conn;
    logic [7:0] sel, rx;
    logic scl, mlow, sda;
    int mismatches = 0, total_checks = 0, cycles = 0;
    assign sda = !(mlow || oe);
    initial clk = 1'b0;
    always #50 clk = ~clk;
    csw_master_model mst_u (.i_clk_sys(clk), .i_up_data(sda),
        .o_up_clk(scl), .o_data_low(mlow));
    csw_switch dut_u (.i_clk_sys(clk), .i_rst_b(rst_b),
        .i_reset_pin_b(pin_b), .i_addr_strap_bit0(strap[0]),
        .i_addr_strap_bit1(strap[1]), .i_addr_strap_bit2(strap[2]),
        .i_up_clk(scl), .i_up_data(sda), .o_up_data_out(dout),
        .o_up_data_oe(oe), .o_ch_connect(conn), .o_channel_select(sel));
    task give_verdict;
        if (mismatches == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            give_verdict;
        end
    end
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask : chk
    function logic [7:0] adr(input logic [2:0] s, input logic rw);
        return {csw_pkg::ADDR_FIXED_HI, s, rw};
    endfunction : adr
    task wr(input logic [2:0] s, input logic [7:0] d, output logic aa,
        output logic da);
        mst_u.start_cond;
        mst_u.byte_xfer(adr(s, 1'b0), 1'b1, rx, aa);
        mst_u.byte_xfer(d, 1'b1, rx, da);
        mst_u.stop_cond;
        mst_u.wait_cyc(4);
    endtask : wr
    task rd(input logic [7:0] exp);
        mst_u.start_cond;
        mst_u.byte_xfer(adr(strap, 1'b1), 1'b1, rx, ack);
        chk("read ack", 8'h00, {7'h00, ack});
        mst_u.byte_xfer(8'hff, 1'b0, rx, ack);
        chk("read data", exp, rx);
        mst_u.byte_xfer(8'hff, 1'b1, rx, ack);
        chk("read again", exp, rx);
        chk("data out", 8'h00, {7'h00, dout});
        mst_u.stop_cond;
        mst_u.wait_cyc(4);
    endtask : rd
    task t_multi;
        mst_u.start_cond;
        mst_u.byte_xfer(adr(strap, 1'b0), 1'b1, rx, ack);
        chk("addr ack", 8'h00, {7'h00, ack});
        mst_u.byte_xfer(8'hf5, 1'b1, rx, ack);
        mst_u.byte_xfer(8'h36, 1'b1, rx, ack);
        chk("data ack", 8'h00, {7'h00, ack});
        chk("register", 8'h36, sel);
        chk("before stop", 8'h00, {4'h0, conn});
        mst_u.stop_cond;
        mst_u.wait_cyc(4);
        chk("after stop", 8'h06, {4'h0, conn});
        rd(8'h36);
    endtask : t_multi
    task t_combo;
        for (int v = 0; v < 16; v++)
        begin
            wr(strap, {~4'(v), 4'(v)}, a0, a1);
            chk("combo", 8'(v), {4'h0, conn});
            rd({~4'(v), 4'(v)});
        end
    endtask : t_combo
    task t_addr;
        strap <= 3'h5;
        mst_u.wait_cyc(4);
        wr(3'h2, 8'h0a, a0, a1);
        chk("foreign nack", 8'h01, {7'h00, a0});
        chk("kept", 8'h0f, {4'h0, conn});
        wr(3'h5, 8'h09, a0, a1);
        chk("strap ack", 8'h00, {7'h00, a0});
        chk("strap conn", 8'h09, {4'h0, conn});
    endtask : t_addr
    task t_reset;
        pin_b <= 1'b0;
        mst_u.wait_cyc(3);
        pin_b <= 1'b1;
        mst_u.wait_cyc(10);
        chk("short pulse", 8'h09, {4'h0, conn});
        pin_b <= 1'b0;
        mst_u.wait_cyc(12);
        pin_b <= 1'b1;
        mst_u.wait_cyc(4);
        chk("pin reg", csw_pkg::CTRL_RESET, sel);
        chk("pin conn", 8'h00, {4'h0, conn});
        wr(strap, 8'h03, a0, a1);
        rst_b <= 1'b0;
        mst_u.wait_cyc(2);
        rst_b <= 1'b1;
        mst_u.wait_cyc(4);
        chk("por conn", 8'h00, {4'h0, conn});
        wr(strap, 8'h05, a0, a1);
        chk("por bus", 8'h05, {4'h0, conn});
    endtask : t_reset
    initial
    begin
        rst_b <= 1'b0;
        pin_b <= 1'b1;
        strap <= 3'h0;
        mst_u.wait_cyc(10);
        rst_b <= 1'b1;
        mst_u.wait_cyc(4);
        chk("reset reg", csw_pkg::CTRL_RESET, sel);
        chk("reset conn", 8'h00, {4'h0, conn});
        t_multi;
        t_combo;
        t_addr;
        t_reset;
        give_verdict;
    end
endmodule : tb
